// ===== core/usart_comm_modes.sv
// serial transceiver: async, sync host/client and host spi framing
`timescale 1ns/1ns
`default_nettype none

// How it works
// - bit clock pin drives out as clock host, is only read as client
// - incoming data is captured on the edge opposite the launch edge
// - inversion 0: rising edge starts a bit, falling edge captures
// - inversion 1: falling edge starts a bit, rising edge captures
// - client transfers follow the external clock only, baud unused
// - spi frames are eight bits with no start, stop or parity
// - bit order select picks lsb or msb first in spi frames
// - spi host makes the clock from the baud divider, one bit per two divider periods
// - each side captures a bit mid-way through its hold period
// - inversion and phase select which edges sample and transmit
// - spi mode reports receive error flags as zero
// - spi mode has no collision, double speed, multi-host or select
// - four receive modes: one double speed, three at sixteen samples
// - async receiver samples sixteen or eight times per bit
// - a falling edge from idle starts detection, first low is sample 1
// - start bit accepted when two of the three middle samples are low
// - start bit rejected when fewer than two middle samples are low
// - data bits decided by majority over the three middle samples
// - only the first stop bit is checked, low flags a frame error
module usart_comm_modes #(
    parameter int TX_FIFO_DEPTH = usart_modes_pkg::FIFO_DEPTH
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // configuration
    input wire usart_modes_pkg::comm_mode_t comm_mode,
    input wire logic [1:0] receive_mode_field,
    input wire logic pin_invert_enable,
    input wire logic clock_phase_select,
    input wire logic bit_order_select,
    input wire logic [15:0] baud_div,
    // transmit stream
    input wire logic tx_valid,
    input wire logic [usart_modes_pkg::DATA_W-1:0] tx_data,
    output logic tx_ready,
    // receive stream and status
    output logic rx_valid,
    output logic [usart_modes_pkg::DATA_W-1:0] rx_data,
    output logic rx_frame_err,
    output logic tx_busy,
    output logic start_reject,
    // serial pins
    input wire logic rxd_in,
    output logic txd_out,
    output logic txd_oe,
    input wire logic bit_clock_pin_in,
    output logic bit_clock_pin_out,
    output logic bit_clock_pin_oe
);
    import usart_modes_pkg::*;

    if (TX_FIFO_DEPTH != FIFO_DEPTH)
    begin : g_bad_depth
        $error("usart_comm_modes: transmit buffer depth must be 16");
    end

    // ******************************************************
    // helpers
    // ******************************************************
    function automatic logic [7:0] rev8(input logic [7:0] d);
        logic [7:0] r;
        r = '0;
        for (int i = 0; i < 8; i++)
            r[i] = d[7-i];
        return r;
    endfunction

    function automatic logic maj3(input logic a, input logic b,
                                  input logic c);
        return (a & b) | (a & c) | (b & c);
    endfunction

    // ******************************************************
    // mode decode
    // ******************************************************
    logic tx_active_r;
    logic lc_r;
    logic lc_prev_r;
    logic xck_meta_r;
    logic xck_s_r;
    logic rxd_meta_r;
    logic rxd_s_r;
    logic [15:0] baud_cnt_r;
    wire fifo_valid;

    // spi is host-only, so no select pin or client path exists
    wire is_async = comm_mode == MODE_ASYNC;
    wire is_spi = comm_mode == MODE_SPI_HOST;
    wire is_client = comm_mode == MODE_SYNC_CLIENT;
    wire is_host = is_spi | (comm_mode == MODE_SYNC_HOST);
    // the two other sixteen-sample modes share the normal path
    wire is_double = receive_mode_field == RECEIVE_MODE_FIELD_DOUBLE;
    wire [3:0] os_last = is_double ? OS_LAST_DOUBLE : OS_LAST_NORMAL;
    wire [3:0] vote_a = is_double ? VOTE_FIRST_DOUBLE : VOTE_FIRST_NORMAL;
    wire [3:0] vote_b = vote_a + 4'h1;
    wire [3:0] vote_c = vote_a + 4'h2;
    wire [3:0] frame_bits = is_spi ? SPI_FRAME_BITS : UART_FRAME_BITS;
    wire [4:0] host_toggles = is_spi ? HOST_TOGGLES_SPI : HOST_TOGGLES_UART;

    // ******************************************************
    // pin synchronisers and baud divider
    // ******************************************************
    // client clock edges are seen even when a level lasts a single sample
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rxd_meta_r <= 1'b1;
            rxd_s_r <= 1'b1;
            xck_meta_r <= 1'b0;
            xck_s_r <= 1'b0;
            lc_prev_r <= 1'b0;
        end
        else
        begin
            rxd_meta_r <= rxd_in;
            rxd_s_r <= rxd_meta_r;
            xck_meta_r <= bit_clock_pin_in;
            xck_s_r <= xck_meta_r;
            lc_prev_r <= xck_s_r ^ pin_invert_enable;
        end
    end

    // divider restarts on a host frame load so the first bit gets a full
    // half period: the looped-back line needs the synchroniser delay
    wire baud_tick = baud_cnt_r == (baud_div - 16'h1);
    wire baud_restart = baud_tick | (is_host & ~tx_active_r & fifo_valid);

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            baud_cnt_r <= BAUD_CNT_RESET;
        else
            baud_cnt_r <= baud_restart ? BAUD_CNT_RESET : baud_cnt_r + 16'h1;
    end

    // ******************************************************
    // bit clock edges
    // ******************************************************
    // logical clock: pin level with inversion taken out, rise starts a bit
    wire lcs = xck_s_r ^ pin_invert_enable;
    wire host_step = is_host & tx_active_r & baud_tick;
    wire lc_rise = is_client ? (lcs & ~lc_prev_r) : (host_step & ~lc_r);
    wire lc_fall = is_client ? (~lcs & lc_prev_r) : (host_step & lc_r);
    // spi phase 0 samples on the leading edge, phase 1 on the trailing
    wire spi_lead_sample = is_spi & ~clock_phase_select;
    wire launch = spi_lead_sample ? lc_fall : lc_rise;
    wire sample = spi_lead_sample ? lc_rise : lc_fall;

    // host clock idles low in logical terms, so the pin idles at inversion
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            lc_r <= 1'b0;
        else if (!tx_active_r)
            lc_r <= 1'b0;
        else if (host_step)
            lc_r <= ~lc_r;
    end

    // ******************************************************
    // transmitter
    // ******************************************************
    logic skip_r;
    logic [9:0] tx_sh_r;
    logic [3:0] tx_os_r;
    logic [3:0] tx_bits_r;
    logic [3:0] tx_samp_r;
    logic [4:0] tog_cnt_r;
    wire [7:0] fifo_data;

    // frame assembly; bit order applies in every mode, lsb first by default
    wire tx_load = ~tx_active_r & fifo_valid;
    wire [7:0] tx_ord = bit_order_select ? rev8(fifo_data) : fifo_data;
    wire [9:0] tx_frame = is_spi ? {2'b11, tx_ord}
                                 : {1'b1, tx_ord, 1'b0};
    // a launch on the leading edge has the first bit already on the line
    wire skip_first = ~is_async & (~is_spi | clock_phase_select);
    wire async_bit = is_async & tx_active_r & baud_tick
                     & (tx_os_r == os_last);
    wire sync_shift = ~is_async & tx_active_r & launch & ~skip_r;
    wire tx_shift = async_bit | sync_shift;
    wire host_done = host_step & (tog_cnt_r == host_toggles - 5'h1);
    wire client_done = is_client & tx_active_r & sample
                       & (tx_samp_r == frame_bits - 4'h1);
    wire async_done = async_bit & (tx_bits_r == frame_bits - 4'h1);
    wire tx_done = host_done | client_done | async_done;

    // shifter and its bit, sample and clock-toggle counters
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tx_active_r <= 1'b0;
            skip_r <= 1'b0;
            tx_sh_r <= TX_IDLE_WORD;
            tx_os_r <= '0;
            tx_bits_r <= '0;
            tx_samp_r <= '0;
            tog_cnt_r <= '0;
        end
        else if (tx_load)
        begin
            tx_active_r <= 1'b1;
            skip_r <= skip_first;
            tx_sh_r <= tx_frame;
            tx_os_r <= '0;
            tx_bits_r <= '0;
            tx_samp_r <= '0;
            tog_cnt_r <= '0;
        end
        else if (tx_done)
        begin
            tx_active_r <= 1'b0;
            tx_sh_r <= TX_IDLE_WORD;
        end
        else if (tx_active_r)
        begin
            if (tx_shift)
            begin
                tx_sh_r <= {1'b1, tx_sh_r[9:1]};
                tx_bits_r <= tx_bits_r + 4'h1;
            end
            if (launch)
                skip_r <= 1'b0;
            if (baud_tick)
                tx_os_r <= (tx_os_r == os_last) ? 4'h0 : tx_os_r + 4'h1;
            if (host_step)
                tog_cnt_r <= tog_cnt_r + 5'h1;
            if (sample)
                tx_samp_r <= tx_samp_r + 4'h1;
        end
    end

    // the buffer drains one word per frame, stalling the writer when full
    stream_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(TX_FIFO_DEPTH)
    ) u_tx_fifo (
        .clk(sys_clk),
        .arst_n(arst_n),
        .s_valid(tx_valid),
        .s_data(tx_data),
        .s_ready(tx_ready),
        .m_valid(fifo_valid),
        .m_data(fifo_data),
        .m_ready(~tx_active_r)
    );

    // ******************************************************
    // receiver
    // ******************************************************
    rx_state_t rx_state_r;
    logic [3:0] rx_pos_r;
    logic [3:0] rx_cnt_r;
    logic [1:0] vote_r;
    logic rx_prev_r;
    logic [7:0] rx_sh_r;

    // start detection and three-sample voting on the oversampling ticks
    wire rx_busy = rx_state_r != RX_IDLE;
    wire maj_now = maj3(vote_r[1], vote_r[0], rxd_s_r);
    wire at_vote = is_async & baud_tick & (rx_pos_r == vote_c);
    wire start_edge = is_async & baud_tick & ~rx_busy
                      & rx_prev_r & ~rxd_s_r;
    wire in_start = rx_state_r == RX_START;
    wire start_ok = at_vote & in_start & ~maj_now;
    wire start_bad = at_vote & in_start & maj_now;
    wire in_frame = (rx_state_r == RX_DATA) | (rx_state_r == RX_STOP);
    wire sync_start = ~is_async & ~is_spi & sample & ~rx_busy & ~rxd_s_r;
    // spi has no start bit, the first capture edge is the first data bit
    wire sync_strobe = ~is_async & sample & (in_frame | (is_spi & ~rx_busy));
    wire rx_strobe = is_async ? (at_vote & in_frame) : sync_strobe;
    wire rx_bit = is_async ? maj_now : rxd_s_r;
    wire rx_last = rx_cnt_r == LAST_DATA_BIT;
    wire spi_push = is_spi & rx_strobe & (rx_last | ~rx_busy) & rx_busy;
    wire rx_push = rx_strobe & ((rx_state_r == RX_STOP) | spi_push);
    wire [7:0] rx_word = is_spi ? {rx_bit, rx_sh_r[7:1]} : rx_sh_r;
    wire [7:0] rx_ord = bit_order_select ? rev8(rx_word) : rx_word;

    // deframer; an idle tick refreshes the last seen line level
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rx_state_r <= RX_IDLE;
            rx_pos_r <= '0;
            rx_cnt_r <= '0;
            vote_r <= 2'b11;
            rx_prev_r <= 1'b0;
            rx_sh_r <= '0;
        end
        else
        begin
            if (baud_tick)
                rx_prev_r <= start_bad ? 1'b0 : rxd_s_r;
            if (baud_tick & rx_busy)
                rx_pos_r <= (rx_pos_r == os_last) ? 4'h0 : rx_pos_r + 4'h1;
            if (is_async & baud_tick
                & (rx_pos_r == vote_a | rx_pos_r == vote_b))
                vote_r <= {vote_r[0], rxd_s_r};
            unique case (rx_state_r)
                RX_IDLE:
                begin
                    rx_cnt_r <= '0;
                    if (start_edge)
                    begin
                        rx_state_r <= RX_START;
                        rx_pos_r <= 4'h1;
                    end
                    else if (sync_start)
                        rx_state_r <= RX_DATA;
                    else if (rx_strobe)
                    begin
                        rx_sh_r <= {rx_bit, rx_sh_r[7:1]};
                        rx_cnt_r <= 4'h1;
                        rx_state_r <= RX_DATA;
                    end
                end
                RX_START:
                begin
                    if (start_ok)
                        rx_state_r <= RX_DATA;
                    else if (start_bad | ~is_async)
                        rx_state_r <= RX_IDLE;
                end
                RX_DATA:
                begin
                    if (rx_strobe)
                    begin
                        rx_sh_r <= {rx_bit, rx_sh_r[7:1]};
                        rx_cnt_r <= rx_cnt_r + 4'h1;
                        if (rx_last)
                            rx_state_r <= is_spi ? RX_IDLE : RX_STOP;
                    end
                end
                RX_STOP:
                begin
                    // a second stop bit is simply idle line to us
                    if (rx_strobe)
                        rx_state_r <= RX_IDLE;
                end
            endcase
        end
    end

    // ******************************************************
    // registered outputs
    // ******************************************************
    // bit clock pin lags the logical clock by one cycle, giving data setup
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rx_valid <= 1'b0;
            rx_data <= '0;
            rx_frame_err <= 1'b0;
            start_reject <= 1'b0;
            tx_busy <= 1'b0;
            txd_oe <= 1'b0;
            bit_clock_pin_out <= 1'b0;
            bit_clock_pin_oe <= 1'b0;
        end
        else
        begin
            rx_valid <= rx_push;
            if (rx_push)
            begin
                rx_data <= rx_ord;
                rx_frame_err <= ~is_spi & ~rx_bit;
            end
            start_reject <= start_bad;
            tx_busy <= tx_load | (tx_active_r & ~tx_done);
            txd_oe <= 1'b1;
            bit_clock_pin_out <= lc_r ^ pin_invert_enable;
            bit_clock_pin_oe <= is_host;
        end
    end

    assign txd_out = tx_sh_r[0];

    // ******************************************************
    // assertions
    // ******************************************************
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);

    property p_clk_dir;
        is_host |=> bit_clock_pin_oe;
    endproperty
    a_clk_dir: assert property (p_clk_dir)
        else $error("bit clock not driven in host mode");

    property p_client_no_drive;
        is_client ##1 is_client |-> !bit_clock_pin_oe;
    endproperty
    a_client_no_drive: assert property (p_client_no_drive)
        else $error("bit clock driven in client mode");

    property p_edges_apart;
        !(launch && sample);
    endproperty
    a_edges_apart: assert property (p_edges_apart)
        else $error("launch and sample on the same edge");

    property p_sync_fall_sample;
        host_step && sample && !is_spi && !pin_invert_enable
        |=> ##1 $fell(bit_clock_pin_out);
    endproperty
    a_sync_fall_sample: assert property (p_sync_fall_sample)
        else $error("sync capture not on falling pin edge");

    property p_sync_rise_sample;
        host_step && sample && !is_spi && pin_invert_enable
        |=> ##1 $rose(bit_clock_pin_out);
    endproperty
    a_sync_rise_sample: assert property (p_sync_rise_sample)
        else $error("inverted sync capture not on rising pin edge");

    property p_client_paced;
        is_client && tx_active_r && !lc_rise && !lc_fall && !tx_load
        |=> $stable(tx_sh_r);
    endproperty
    a_client_paced: assert property (p_client_paced)
        else $error("client transmitter moved without a clock edge");

    property p_spi_len;
        host_done && is_spi |-> tog_cnt_r == 5'd15;
    endproperty
    a_spi_len: assert property (p_spi_len)
        else $error("spi frame not sixteen clock toggles");

    property p_spi_hold;
        is_spi && tx_active_r && !launch && !tx_load && !tx_done
        |=> $stable(txd_out);
    endproperty
    a_spi_hold: assert property (p_spi_hold)
        else $error("spi data changed off the transmit edge");

    property p_spi_phase0_rise;
        is_spi && !clock_phase_select && sample |-> !lc_r;
    endproperty
    a_spi_phase0_rise: assert property (p_spi_phase0_rise)
        else $error("spi phase 0 sample not on leading edge");

    property p_spi_no_err;
        is_spi && rx_valid |-> !rx_frame_err;
    endproperty
    a_spi_no_err: assert property (p_spi_no_err)
        else $error("error flag raised in spi mode");

    property p_double_pos;
        is_double && is_async && rx_busy |-> rx_pos_r <= 4'd7;
    endproperty
    a_double_pos: assert property (p_double_pos)
        else $error("double speed sample position past eight");

    property p_start_accept;
        start_ok |=> rx_state_r == RX_DATA;
    endproperty
    a_start_accept: assert property (p_start_accept)
        else $error("valid start bit not accepted");

    property p_start_reject;
        start_bad |=> rx_state_r == RX_IDLE && !rx_prev_r ##0 start_reject;
    endproperty
    a_start_reject: assert property (p_start_reject)
        else $error("bad start bit not rejected");

    property p_stop_err;
        rx_strobe && rx_state_r == RX_STOP && !rx_bit
        |=> rx_valid && rx_frame_err;
    endproperty
    a_stop_err: assert property (p_stop_err)
        else $error("low stop bit without frame error");

    c_spi_frame: cover property (is_spi && host_done);
    c_async_rx: cover property (is_async && rx_valid);
    c_reject: cover property (start_reject);
    c_client_rx: cover property (is_client && rx_valid);

endmodule

`default_nettype wire

// ===== shared/usart_modes_pkg.sv
// constants and types shared by the serial communication-mode block
package usart_modes_pkg;

    // operating modes of the transceiver
    typedef enum logic [1:0] {
        MODE_ASYNC,
        MODE_SYNC_HOST,
        MODE_SYNC_CLIENT,
        MODE_SPI_HOST
    } comm_mode_t;

    // receive deframer states
    typedef enum logic [1:0] {
        RX_IDLE,
        RX_START,
        RX_DATA,
        RX_STOP
    } rx_state_t;

    // data width and transmit buffer depth
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 16;

    // frame lengths in bits: start, eight data, stop / bare eight data
    localparam logic [3:0] UART_FRAME_BITS = 4'ha;
    localparam logic [3:0] SPI_FRAME_BITS = 4'h8;
    localparam logic [3:0] LAST_DATA_BIT = 4'h7;

    // host clock toggles per frame, two per bit
    localparam logic [4:0] HOST_TOGGLES_UART = 5'h14;
    localparam logic [4:0] HOST_TOGGLES_SPI = 5'h10;

    // oversampling: last position index per bit, position 0 is sample 1
    localparam logic [3:0] OS_LAST_NORMAL = 4'hf;
    localparam logic [3:0] OS_LAST_DOUBLE = 4'h7;

    // first vote position: sample 8 normal, sample 4 double speed
    localparam logic [3:0] VOTE_FIRST_NORMAL = 4'h7;
    localparam logic [3:0] VOTE_FIRST_DOUBLE = 4'h3;

    // receive mode field encoding of double speed
    localparam logic [1:0] RECEIVE_MODE_FIELD_DOUBLE = 2'h1;

    // idle line and reset values
    localparam logic [9:0] TX_IDLE_WORD = 10'h3ff;
    localparam logic [15:0] BAUD_CNT_RESET = 16'h0000;

endpackage

// ===== core/stream_fifo.sv
// small valid/ready fifo holding words on their way to the transmitter
`timescale 1ns/1ns
`default_nettype none

module stream_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
)
(
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // filling side
    input wire logic s_valid,
    input wire logic [WIDTH-1:0] s_data,
    output logic s_ready,
    // draining side
    output logic m_valid,
    output logic [WIDTH-1:0] m_data,
    input wire logic m_ready
);

    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);

    // pointers wrap naturally, so only powers of two are served
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
    begin : g_bad_param
        $error("stream_fifo: DEPTH must be a power of two >= 2");
    end

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] count_r;

    // handshakes and next fill level
    wire push = s_valid & s_ready;
    wire pop = m_valid & m_ready;
    wire [AW:0] count_nxt = count_r + {{AW{1'b0}}, push}
                            - {{AW{1'b0}}, pop};
    assign m_valid = count_r != '0;
    assign m_data = mem_r[rd_ptr_r];

    // storage has no reset, contents are qualified by the count
    always_ff @(posedge clk)
    begin
        if (push)
            mem_r[wr_ptr_r] <= s_data;
    end

    // pointers, fill level and registered ready
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
            s_ready <= 1'b0;
        end
        else
        begin
            wr_ptr_r <= wr_ptr_r + AW'(push);
            rd_ptr_r <= rd_ptr_r + AW'(pop);
            count_r <= count_nxt;
            s_ready <= count_nxt != FULL_COUNT;
        end
    end

endmodule

`default_nettype wire

// ===== dv/serial_echo.sv
// far-end model: echoes the serial line back, can inject a low glitch
`timescale 1ns/1ns
`default_nettype none
module serial_echo
(
    // clock
    input wire logic sys_clk,
    // line in from the block, glitch request, line back out
    input wire logic line_in,
    input wire logic [7:0] glitch_len,
    output logic line_out
);
    logic [7:0] cnt_r = 8'h00;
    // glitch too short to survive the start-bit vote
    always_ff @(posedge sys_clk)
    begin
        if (glitch_len != 8'h00)
            cnt_r <= glitch_len;
        else if (cnt_r != 8'h00)
            cnt_r <= cnt_r - 8'h01;
    end
    assign line_out = line_in & (cnt_r == 8'h00);
endmodule
`default_nettype wire

// ===== dv/usart_comm_modes_bench.sv
// loopback bench: frames in every mode checked against a queue
`timescale 1ns/1ns
`default_nettype none
module usart_comm_modes_bench;
    import usart_modes_pkg::*;
    logic sys_clk = 1'b0, arst_n = 1'b0, inv = 1'b0, ph = 1'b0;
    logic ord = 1'b0, tx_valid = 1'b0, full_seen = 1'b0, ext_clk = 1'b0;
    logic tx_ready, rx_valid, ferr, rej, txd, rxd, oe, txoe, busy;
    comm_mode_t mode = MODE_ASYNC;
    logic [1:0] rxm = 2'h0;
    logic [7:0] tx_data = 8'h00, glen = 8'h00, rx_data;
    logic [7:0] exp_q[$];
    int bad_count = 0, n_compared = 0, rejects = 0, seed = 37;
    // 50 MHz clock
    initial
    begin
        forever #10 sys_clk = ~sys_clk;
    end
    usart_comm_modes u_dut (.sys_clk(sys_clk), .arst_n(arst_n),
        .comm_mode(mode), .receive_mode_field(rxm), .pin_invert_enable(inv),
        .clock_phase_select(ph), .bit_order_select(ord),
        .baud_div(16'h0004), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_frame_err(ferr), .tx_busy(busy), .start_reject(rej),
        .rxd_in(rxd), .txd_out(txd), .txd_oe(txoe),
        .bit_clock_pin_in(ext_clk),
        .bit_clock_pin_out(), .bit_clock_pin_oe(oe));
    serial_echo u_far (.sys_clk(sys_clk), .line_in(txd),
        .glitch_len(glen), .line_out(rxd));
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic results();
        $display("mismatches %0d of %0d compared", bad_count, n_compared);
        if (bad_count == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // hold the word until the buffer takes it
    task automatic send(input logic [7:0] d);
        int i;
        exp_q.push_back(d);
        tx_valid <= 1'b1;
        tx_data <= d;
        // look at ready only where it has settled
        @(negedge sys_clk);
        for (i = 0; i < 20000 && tx_ready !== 1'b1; i++)
            @(negedge sys_clk);
        if (i == 20000)
            bad_count++;
        if (i == 20000)
            results();
        @(posedge sys_clk);
    endtask
    // wait until every noted byte came back and the shifter is idle
    task automatic drain();
        int i;
        tx_valid <= 1'b0;
        for (i = 0; i < 20000 && (exp_q.size() > 0 || busy !== 1'b0); i++)
            @(negedge sys_clk);
        if (i == 20000)
            bad_count++;
        if (i == 20000)
            results();
        @(posedge sys_clk);
    endtask
    // client frame: external clock runs only inside the frame, slow levels
    task automatic client_frame(input logic [7:0] d);
        send(d);
        tx_valid <= 1'b0;
        repeat (4) @(posedge sys_clk);
        repeat (20)
        begin
            repeat (8) @(posedge sys_clk);
            ext_clk <= ~ext_clk;
        end
        drain();
    endtask
    // watcher: oldest note against each received byte
    always @(negedge sys_clk)
    begin
        if (rej === 1'b1)
            rejects++;
        if (tx_ready === 1'b0 && arst_n)
            full_seen <= 1'b1;
        if (rx_valid === 1'b1)
        begin
            check(rx_data, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);
            check({7'h00, ferr}, 8'h00);
        end
    end
    initial
    begin
        repeat (20) @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        check({6'h00, oe, txoe}, 8'h01);
        // back-to-back words fill the buffer until the writer stalls, 16x sampling
        repeat (18) send(8'($random(seed)));
        drain();
        check({7'h00, full_seen}, 8'h01);
        rxm <= RECEIVE_MODE_FIELD_DOUBLE;
        ord <= 1'b1;
        @(posedge sys_clk);
        repeat (3) send(8'($random(seed)));
        drain();
        // short low pulse is refused, next frame still lands
        glen <= 8'h04;
        @(posedge sys_clk);
        glen <= 8'h00;
        repeat (100) @(posedge sys_clk);
        check(8'(rejects), 8'h01);
        send(8'h5a);
        drain();
        // host modes over all edge settings and both bit orders
        for (int k = 0; k < 8; k++)
        begin
            mode <= k < 4 ? MODE_SPI_HOST : MODE_SYNC_HOST;
            {inv, ph} <= 2'(k);
            ord <= k[0] ^ k[2];
            repeat (3) @(posedge sys_clk);
            check({7'h00, oe}, 8'h01);
            send(8'($random(seed)));
            send(8'($random(seed)));
            drain();
        end
        // clock client: frames paced by the bench's own bit clock
        mode <= MODE_SYNC_CLIENT;
        {inv, ph} <= 2'b00;
        repeat (3) @(posedge sys_clk);
        check({7'h00, oe}, 8'h00);
        client_frame(8'($random(seed)));
        client_frame(8'h3c);
        results();
    end
endmodule
`default_nettype wire
